/* File: rtl/dsw_defines.svh */
// constants for the dac serial write port
`ifndef DSW_DEFINES_SVH
`define DSW_DEFINES_SVH
`define DSW_WIDE_BITS      24
`define DSW_NARROW_BITS    16
`define DSW_RES_WIDE       16
`define DSW_CNT_W          5
`define DSW_DAC_RESET      16'h0000
`define DSW_SR_RESET       24'h000000
`define DSW_CLK_NS         50
`define DSW_SCLK_MAX_HI_MHZ 30
`define DSW_SCLK_MAX_LO_MHZ 20
`endif

/* File: rtl/dsw_pkg.sv */
// types for the dac serial write port
package dsw_pkg;
	typedef struct packed {
		logic frameN;
		logic sclk;
		logic din;
	} dsw_pins_s;
	typedef struct packed {
		logic        strobe;
		logic [15:0] code;
	} dsw_load_s;
endpackage

/* File: rtl/dsw_sync.sv */
// two-flop synchroniser for the serial pins
`timescale 1ns/1ps
`default_nettype none
module dsw_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] asyncIn,
	output var  logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_reg;
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			stage1_reg <= '1;
			syncOut    <= '1;
		end else begin
			stage1_reg <= asyncIn;
			syncOut    <= stage1_reg;
		end
	end
endmodule
`default_nettype wire

/* File: rtl/dsw_serial_port.sv */
// serial write port of a single-channel voltage-output dac
// Function
// - shift register is enabled only while active-low frame select is low
// - one data bit is captured on each serial clock falling edge in a frame until the last counted one
// - dac loads after the 24th (wide) or 16th (narrow) clock of a frame
// - frame select rising after the first but before the last counted edge aborts; dac unchanged
// - shift register is 24 bits wide or 16 bits wide per variant
// - loaded code is straight unsigned binary, zero lowest, all ones full scale
`timescale 1ns/1ps
`default_nettype none
`include "dsw_defines.svh"
module dsw_serial_port #(
	parameter int RES_BITS = `DSW_RES_WIDE
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic         frameN,
	input  wire logic         sclk,
	input  wire logic         din,
	output var  logic [15:0]  dacCode,
	output var  logic         dacLoad,
	output var  logic         frameAbort
);
	// the 16-bit variant takes 24-bit frames, the narrower ones 16-bit frames
	localparam int SR_BITS = (RES_BITS == `DSW_RES_WIDE) ? `DSW_WIDE_BITS : `DSW_NARROW_BITS;
	localparam int CNT_BITS  = `DSW_CNT_W;
	localparam int CODE_BITS = $bits(dacCode);

	// counter end points, sized to the counter so no compare pads or drops bits
	localparam logic [CNT_BITS-1:0] LAST_CNT = CNT_BITS'(SR_BITS);
	localparam logic [CNT_BITS-1:0] CNT_ONE  = CNT_BITS'(1);
	localparam logic [CNT_BITS-1:0] CNT_ZERO = CNT_BITS'(0);
	localparam logic [CNT_BITS-1:0] CNT_PRE  = LAST_CNT - CNT_ONE;

	// shift register start value, cut to the variant's width on purpose
	localparam logic [SR_BITS-1:0]  SR_INIT  = SR_BITS'(`DSW_SR_RESET);

	// frame progress; gray along idle -> shift -> done, so one bit moves per step
	typedef enum logic [1:0] {
		DSW_IDLE  = 2'b00,
		DSW_SHIFT = 2'b01,
		DSW_DONE  = 2'b11
	} dsw_state_e;

	// synchronised pins, carried together so they share one latency
	dsw_pkg::dsw_pins_s    pinsRaw;
	dsw_pkg::dsw_pins_s    pinsSync;

	// load request towards the output register
	dsw_pkg::dsw_load_s    loadNext;

	// edge detector history; idles high like the pins, so no false edge after reset
	logic                  frameNPrev_reg;
	logic                  sclkPrev_reg;

	// frame state
	dsw_state_e            state_reg;
	dsw_state_e            state_next;

	// received bits and their count
	logic [SR_BITS-1:0]    shift_reg;
	logic [SR_BITS-1:0]    shift_next;
	logic [SR_BITS-1:0]    shiftIn;
	logic [SR_BITS-1:0]    startWord;
	logic [CNT_BITS-1:0]   count_reg;
	logic [CNT_BITS-1:0]   count_next;

	assign pinsRaw = '{frameN: frameN, sclk: sclk, din: din};

	// all three pins come from the host's domain and pass two flops first
	dsw_sync #(
		.WIDTH ($bits(dsw_pkg::dsw_pins_s))
	) u_sync (
		.clk     (clk),
		.reset   (reset),
		.asyncIn (pinsRaw),
		.syncOut (pinsSync)
	);

	// pin decoding
	wire frameActive = ~pinsSync.frameN;
	wire frameStart  = frameNPrev_reg & ~pinsSync.frameN;
	wire frameEnd    = ~frameNPrev_reg & pinsSync.frameN;
	wire sclkFall    = sclkPrev_reg & ~pinsSync.sclk;

	// state decoding
	wire inIdle      = (state_reg == DSW_IDLE);
	wire inShift     = (state_reg == DSW_SHIFT);
	wire inDone      = (state_reg == DSW_DONE);

	// a falling clock edge in the same cycle as the frame start is counted as bit one
	wire firstBit    = frameStart & sclkFall;

	// bits are only taken while selected and not yet full; extra edges are ignored
	wire bitTake     = inShift & frameActive & ~frameStart & sclkFall;
	wire atLast      = (count_reg == CNT_PRE);
	wire lastBit     = bitTake & atLast;

	// a frame cut after at least one bit is an abort; an empty frame is not
	wire hasBits     = (count_reg != CNT_ZERO);
	wire abortNow    = frameEnd & inShift & hasBits;

	// next frame state
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			DSW_IDLE: begin
				if (frameStart) begin
					state_next = DSW_SHIFT;
				end
			end
			DSW_SHIFT: begin
				if (frameEnd) begin
					state_next = DSW_IDLE;
				end else if (lastBit) begin
					state_next = DSW_DONE;
				end
			end
			DSW_DONE: begin
				if (frameEnd) begin
					state_next = DSW_IDLE;
				end
			end
			default: begin
				// the unused code falls back to idle rather than locking up
				state_next = DSW_IDLE;
			end
		endcase
		// a new frame always restarts, whatever the previous one left behind
		if (frameStart) begin
			state_next = DSW_SHIFT;
		end
	end

	// bit counter: set to zero on frame start, or to one when bit one comes with it; one step per taken bit
	assign count_next = frameStart ? (firstBit ? CNT_ONE : CNT_ZERO)
	                  : bitTake ? count_reg + CNT_ONE
	                  : count_reg;

	// word seen from the shift register with the current bit appended, msb first
	assign shiftIn   = {shift_reg[SR_BITS-2:0], pinsSync.din};

	// start value: empty, or holding bit one when it arrived with the frame start
	assign startWord = SR_BITS'(firstBit & pinsSync.din);

	// one cell per bit: restart, shift in from below, or hold
	genvar gi;
	generate
		for (gi = 0; gi < SR_BITS; gi++) begin : g_cell
			assign shift_next[gi] = frameStart ? startWord[gi]
			                      : bitTake ? shiftIn[gi]
			                      : shift_reg[gi];
		end
	endgenerate

	// the code is the last received bits, taken as straight binary with no sign
	assign loadNext.strobe = lastBit;
	assign loadNext.code   = shiftIn[CODE_BITS-1:0];

	// edge history
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			frameNPrev_reg <= 1'b1;
			sclkPrev_reg   <= 1'b1;
		end else begin
			frameNPrev_reg <= pinsSync.frameN;
			sclkPrev_reg   <= pinsSync.sclk;
		end
	end

	// frame state and count
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= DSW_IDLE;
			count_reg <= CNT_ZERO;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
		end
	end

	// shift register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			shift_reg <= SR_INIT;
		end else begin
			shift_reg <= shift_next;
		end
	end

	// dac only changes on a complete frame, so an abort leaves it as it was
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dacCode <= `DSW_DAC_RESET;
		end else if (loadNext.strobe) begin
			dacCode <= loadNext.code;
		end
	end

	// one-cycle status pulses
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			dacLoad    <= 1'b0;
			frameAbort <= 1'b0;
		end else begin
			dacLoad    <= loadNext.strobe;
			frameAbort <= abortNow;
		end
	end

	// the idle and done states are only observed by the decode above
	wire unusedState = inIdle & inDone;
endmodule
`default_nettype wire

/* File: sim/dsw_serial_port_asserts.sv */
// pin-level assertions for the dac serial write port
`timescale 1ns/1ps
`default_nettype none
module dsw_serial_port_asserts #(parameter int RES_BITS = 16) (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        frameN,
	input wire logic        sclk,
	input wire logic        din,
	input wire logic        dacLoad,
	input wire logic        frameAbort,
	input wire logic [15:0] dacCode
);
	localparam int N = RES_BITS == 16 ? 24 : 16;
	logic [4:0]  cnt;
	logic [15:0] sh;
	logic        sPrev;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// raw-pin shadow of the frame; clearing its count while deselected exposes residue
	always_ff @(posedge clk or posedge reset) begin
		if (reset) {cnt, sh, sPrev} <= 22'h000001;
		else begin
			sPrev <= sclk;
			cnt <= frameN ? 5'h00 : cnt + 5'(sPrev & ~sclk);
			if (sPrev & ~sclk & ~frameN) sh <= {sh[14:0], din};
		end
	end
	a_ld_one: assert property (dacLoad |=> !dacLoad) else $error("long load");
	a_ld_cnt: assert property (dacLoad |-> cnt == N) else $error("load count");
	a_ld_data: assert property (dacLoad |-> dacCode == sh) else $error("load data");
	a_ld_frame: assert property (dacLoad |-> !$past(frameN, 5)) else $error("load off frame");
	a_ab_one: assert property (frameAbort |=> !frameAbort) else $error("long abort");
	a_ab_rise: assert property (frameAbort |-> frameN && $past(frameN, 2)) else $error("stray abort");
	a_code_hold: assert property (!dacLoad |-> $stable(dacCode)) else $error("code moved");
endmodule
bind dsw_serial_port dsw_serial_port_asserts #(.RES_BITS(RES_BITS)) u_chk (.clk(clk), .reset(reset),
	.frameN(frameN), .sclk(sclk), .din(din), .dacCode(dacCode), .dacLoad(dacLoad), .frameAbort(frameAbort));
`default_nettype wire

/* File: sim/dsw_host_model.sv */
// host serial master model
`timescale 1ns/1ps
`default_nettype none
module dsw_host_model (
	input  wire logic clk,
	output var  logic frameN,
	output var  logic sclk,
	output var  logic din
);
	initial {frameN, sclk, din} = 3'b110;
	// s bits of an n-bit word, msb first; s < n cuts the frame; clock idles high outside frames
	task automatic send(input logic [23:0] w, input int n, input int s);
		@(posedge clk);
		frameN <= 1'b0;
		for (int i = 1; i <= s; i++) begin
			din <= w[n - i];
			repeat (4) @(posedge clk);
			sclk <= 1'b0; // 400 ns period, well inside either limit
			repeat (4) @(posedge clk);
			sclk <= 1'b1;
		end
		repeat (4) @(posedge clk);
		frameN <= 1'b1;
		din    <= ~din;
		repeat (20) @(posedge clk);
	endtask
endmodule
`default_nettype wire

/* File: sim/tb_top.sv */
// random and corner frames through the serial write port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk, reset, frameN, sclk, din, dacLoad, frameAbort;
	logic        dacLoadN, frameAbortN;
	logic [15:0] dacCode, want, dacCodeN, wantN;
	logic [23:0] w;
	logic [7:0]  nLoad, nAbort, nLoadN, nAbortN;
	logic [31:0] cnt0;
	int          n_fail, tests_run, cyc, s;
	dsw_serial_port u_dut (.clk(clk), .reset(reset), .frameN(frameN), .sclk(sclk), .din(din),
		.dacCode(dacCode), .dacLoad(dacLoad), .frameAbort(frameAbort));
	// narrow variant on the same pins: loads after 16 bits and ignores the rest
	dsw_serial_port #(.RES_BITS(12)) u_dut_narrow (.clk(clk), .reset(reset), .frameN(frameN), .sclk(sclk),
		.din(din), .dacCode(dacCodeN), .dacLoad(dacLoadN), .frameAbort(frameAbortN));
	dsw_host_model u_host (.clk(clk), .frameN(frameN), .sclk(sclk), .din(din));
	// pulses counted mid-cycle, where the registered outputs are settled
	always @(negedge clk) begin
		if (reset) {nLoad, nAbort, nLoadN, nAbortN} <= 32'h00000000;
		else begin
			nLoad   <= nLoad + 8'(dacLoad);
			nAbort  <= nAbort + 8'(frameAbort);
			nLoadN  <= nLoadN + 8'(dacLoadN);
			nAbortN <= nAbortN + 8'(frameAbortN);
		end
	end
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) if (++cyc == 9000) begin
		n_fail++;
		results();
	end
	function logic [15:0] code_of(input logic [23:0] x);
		return x[15:0];
	endfunction
	function logic [15:0] code_narrow(input logic [23:0] x);
		return x[23:8];
	endfunction
	task chk_cnt(input logic [7:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected pulse count at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	task chk(input logic [15:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	task results;
		$display("%0d compares, %0d failed", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		reset = 1;
		{cyc, n_fail, tests_run, want, wantN} = 0;
		void'($urandom(32'hF0BDBB7E));
		repeat (6) @(posedge clk);
		reset <= 0;
		repeat (3) @(posedge clk);
		for (int k = 0; k < 24; k++) begin
			w = k < 2 ? {24{k[0]}} : 24'($urandom);
			s = k == 2 ? 23 : k == 3 ? 0 : k == 4 ? 15 : k == 5 ? 16 : k % 3 == 2 ? 1 + $urandom % 23 : 24;
			cnt0 = {nLoad, nAbort, nLoadN, nAbortN};
			u_host.send(w, 24, s);
			if (s == 24) want = code_of(w);
			if (s >= 16) wantN = code_narrow(w);
			@(posedge clk);
			chk(dacCode, want);
			chk(dacCodeN, wantN);
			chk_cnt(8'(nLoad - cnt0[31:24]), 8'(s == 24));
			chk_cnt(8'(nAbort - cnt0[23:16]), 8'(s > 0 && s < 24));
			chk_cnt(8'(nLoadN - cnt0[15:8]), 8'(s >= 16));
			chk_cnt(8'(nAbortN - cnt0[7:0]), 8'(s > 0 && s < 16));
		end
		results();
	end
endmodule
`default_nettype wire
